// ===== logic/pfs_pkg.sv
package pfs_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ            = 25000000;
    localparam int PERSIST_US        = 10;
    localparam int PERSIST_CYC       = (CLK_HZ / 1000000) * PERSIST_US;
    localparam int PERSIST_W         = 16;
    localparam int RELEASE_MS        = 4;
    localparam int RELEASE_CYC       = (CLK_HZ / 1000) * RELEASE_MS;
    localparam int SHORT_STEP_US     = 100;
    localparam int SHORT_STEP_CYC    = (CLK_HZ / 1000000) * SHORT_STEP_US;
    localparam int RECHARGE_NS       = 30;
    localparam int RECHARGE_CYC      = (RECHARGE_NS * 25 + 999) / 1000;
    localparam int CNT_W             = 24;

    // ------------------------------------------------------------------
    // Wishbone register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_HIZ    = 8'h08;

    // Control register fields.
    localparam int CTRL_MODE_LSB    = 0;
    localparam int CTRL_HOLD_AB     = 2;
    localparam int CTRL_HOLD_CD     = 3;
    localparam logic [31:0] CTRL_RESET = 32'h0000000C;

    // Status register fields.
    localparam int ST_SD_N     = 0;
    localparam int ST_WARN_N   = 1;
    localparam int ST_THERM    = 2;
    localparam int ST_OL_AB    = 3;
    localparam int ST_OL_CD    = 4;
    localparam int ST_UV       = 5;
    localparam int ST_SHORTCHK = 6;
    localparam int ST_SHORTFND = 7;

    // Output mode encodings.
    localparam logic [1:0] MODE_BRIDGED  = 2'h0;
    localparam logic [1:0] MODE_PARALLEL = 2'h1;
    localparam logic [1:0] MODE_SINGLE   = 2'h2;

    // Startup pin-short check states.
    typedef enum logic [3:0] {
        CHK_IDLE   = 4'h1,
        CHK_GROUND = 4'h2,
        CHK_SUPPLY = 4'h4,
        CHK_DONE   = 4'h8
    } pfs_chk_t;

endpackage : pfs_pkg

// ===== logic/pfs_pair_guard.sv
`timescale 1ns/1ns
// Current limiting and latching overload for one half-bridge pair.
module pfs_pair_guard (
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    input  wire logic trip_in,
    input  wire logic release_in,
    output logic      limit_out,
    output logic      overload_out
);

    logic [pfs_pkg::PERSIST_W-1:0] persist_reg;
    logic                          overload_reg;

    // Counts consecutive trip cycles; a short trip only limits current.
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            persist_reg <= '0;
        else if (!trip_in || overload_reg)
            persist_reg <= '0;
        else if (persist_reg != pfs_pkg::PERSIST_W'(pfs_pkg::PERSIST_CYC))
            persist_reg <= persist_reg + 1'b1;
    end

    // Overload latch; a persisting trip wins over a release.
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            overload_reg <= 1'b0;
        else if (persist_reg == pfs_pkg::PERSIST_W'(pfs_pkg::PERSIST_CYC))
            overload_reg <= 1'b1;
        else if (release_in)
            overload_reg <= 1'b0;
    end

    // Limiting is combinational so it acts at once on a trip.
    assign limit_out    = trip_in && !overload_reg;
    assign overload_out = overload_reg;

endmodule : pfs_pair_guard

// ===== logic/pfs_supervisor.sv
// Implementation choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ns
module pfs_supervisor (
    input  wire logic        MCLK_IN,
    input  wire logic        RESET_N_IN,
    // Wishbone slave.
    input  wire logic        WB_CYC_IN,
    input  wire logic        WB_STB_IN,
    input  wire logic        WB_WE_IN,
    input  wire logic [7:0]  WB_ADR_IN,
    input  wire logic [3:0]  WB_SEL_IN,
    input  wire logic [31:0] WB_DAT_IN,
    output logic      [31:0] WB_DAT_OUT,
    output logic             WB_ACK_OUT,
    // Controller hold pins and analog fault sensors, asynchronous.
    input  wire logic        PAIR_AB_HOLD_N_IN,
    input  wire logic        PAIR_CD_HOLD_N_IN,
    input  wire logic        SUPPLY_UNDERVOLT_FAULT_IN,
    input  wire logic        TEMP_WARN_IN,
    input  wire logic        TEMP_SHUTDOWN_IN,
    input  wire logic [3:0]  OVERCURRENT_TRIP_IN,
    input  wire logic [3:0]  BOOTSTRAP_UNDERVOLT_IN,
    input  wire logic [3:0]  LOCAL_ERROR_IN,
    input  wire logic [3:0]  PIN_SHORT_GND_IN,
    input  wire logic [3:0]  PIN_SHORT_SUPPLY_IN,
    // Power-stage controls.
    output logic      [3:0]  BRIDGE_HIZ_OUT,
    output logic      [3:0]  CURRENT_LIMIT_OUT,
    output logic      [3:0]  RECHARGE_OUT,
    output logic      [1:0]  CHECK_STEP_OUT,
    // Open-drain fault pins.
    output logic             SHUTDOWN_FAULT_N_OUT,
    output logic             SHUTDOWN_FAULT_N_OE_OUT,
    output logic             THERMAL_WARN_N_OUT,
    output logic             THERMAL_WARN_N_OE_OUT
);

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    localparam int SYNC_W = 25;
    logic [SYNC_W-1:0] meta_reg;
    logic [SYNC_W-1:0] sync_reg;
    logic [SYNC_W-1:0] raw_in;

    assign raw_in = {PAIR_AB_HOLD_N_IN, PAIR_CD_HOLD_N_IN, SUPPLY_UNDERVOLT_FAULT_IN,
                     TEMP_WARN_IN, TEMP_SHUTDOWN_IN, OVERCURRENT_TRIP_IN,
                     BOOTSTRAP_UNDERVOLT_IN, LOCAL_ERROR_IN, PIN_SHORT_GND_IN,
                     PIN_SHORT_SUPPLY_IN};

    // Two flip-flops per bit; only the second stage is read.
    genvar gi;
    generate
        for (gi = 0; gi < SYNC_W; gi++)
        begin : g_sync
            always_ff @(posedge MCLK_IN or negedge RESET_N_IN)
            begin
                if (!RESET_N_IN)
                begin
                    meta_reg[gi] <= (gi >= SYNC_W - 2); // Hold pins reset to their idle high level.
                    sync_reg[gi] <= (gi >= SYNC_W - 2);
                end
                else
                begin
                    meta_reg[gi] <= raw_in[gi];
                    sync_reg[gi] <= meta_reg[gi];
                end
            end
        end
    endgenerate

    logic       hold_ab_pin;
    logic       hold_cd_pin;
    logic       uv;
    logic       twarn;
    logic       tshut;
    logic [3:0] oc;
    logic [3:0] bst_uv;
    logic [3:0] lerr;
    logic [3:0] sh_gnd;
    logic [3:0] sh_sup;

    assign {hold_ab_pin, hold_cd_pin, uv, twarn, tshut, oc, bst_uv, lerr, sh_gnd, sh_sup} = sync_reg;

    // ------------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------------
    logic [31:0] ctrl_reg;
    logic        ack_reg;
    logic [31:0] rdata_reg;
    logic [31:0] status;
    logic        wb_req;

    assign wb_req = WB_CYC_IN && WB_STB_IN && !ack_reg;

    // Control writes, byte lane 0 only carries fields.
    always_ff @(posedge MCLK_IN or negedge RESET_N_IN)
    begin
        if (!RESET_N_IN)
            ctrl_reg <= pfs_pkg::CTRL_RESET;
        else if (wb_req && WB_WE_IN && WB_ADR_IN == pfs_pkg::ADDR_CTRL && WB_SEL_IN[0])
            ctrl_reg <= {24'h000000, 4'h0, WB_DAT_IN[3:0]};
    end

    // One-wait-state acknowledge and read data; unmapped reads give zero.
    always_ff @(posedge MCLK_IN or negedge RESET_N_IN)
    begin
        if (!RESET_N_IN)
        begin
            ack_reg   <= 1'b0;
            rdata_reg <= 32'h00000000;
        end
        else
        begin
            ack_reg <= wb_req;
            if (wb_req)
            begin
                case (WB_ADR_IN)
                    pfs_pkg::ADDR_CTRL:   rdata_reg <= ctrl_reg;
                    pfs_pkg::ADDR_STATUS: rdata_reg <= status;
                    pfs_pkg::ADDR_HIZ:    rdata_reg <= {28'h0000000, BRIDGE_HIZ_OUT};
                    default:              rdata_reg <= 32'h00000000;
                endcase
            end
        end
    end

    assign WB_ACK_OUT = ack_reg;
    assign WB_DAT_OUT = rdata_reg;

    // Mode is static configuration.
    logic [1:0] mode;
    logic       hold_ab_n;
    logic       hold_cd_n;
    assign mode      = ctrl_reg[pfs_pkg::CTRL_MODE_LSB +: 2];
    assign hold_ab_n = hold_ab_pin && ctrl_reg[pfs_pkg::CTRL_HOLD_AB];
    assign hold_cd_n = hold_cd_pin && ctrl_reg[pfs_pkg::CTRL_HOLD_CD];

    // ------------------------------------------------------------------
    // Startup pin-short check
    // ------------------------------------------------------------------
    pfs_pkg::pfs_chk_t chk_reg;
    logic [pfs_pkg::CNT_W-1:0] step_reg;
    logic short_found_reg;
    logic checking;

    // Runs once after reset release; later shorts are ignored.
    always_ff @(posedge MCLK_IN or negedge RESET_N_IN)
    begin
        if (!RESET_N_IN)
        begin
            chk_reg         <= pfs_pkg::CHK_IDLE;
            step_reg        <= '0;
            short_found_reg <= 1'b0;
        end
        else
        begin
            case (chk_reg)
                pfs_pkg::CHK_IDLE:
                begin
                    step_reg <= '0;
                    if (mode == pfs_pkg::MODE_SINGLE)
                        chk_reg <= pfs_pkg::CHK_DONE;
                    else
                        chk_reg <= pfs_pkg::CHK_GROUND;
                end
                pfs_pkg::CHK_GROUND:
                begin
                    short_found_reg <= |sh_gnd;
                    if (|sh_gnd)
                        step_reg <= '0;
                    else if (step_reg == pfs_pkg::CNT_W'(pfs_pkg::SHORT_STEP_CYC - 1))
                    begin
                        step_reg <= '0;
                        chk_reg  <= pfs_pkg::CHK_SUPPLY;
                    end
                    else
                        step_reg <= step_reg + 1'b1;
                end
                pfs_pkg::CHK_SUPPLY:
                begin
                    short_found_reg <= |sh_sup;
                    if (|sh_sup)
                        step_reg <= '0;
                    else if (step_reg == pfs_pkg::CNT_W'(pfs_pkg::SHORT_STEP_CYC - 1))
                        chk_reg <= pfs_pkg::CHK_DONE;
                    else
                        step_reg <= step_reg + 1'b1;
                end
                pfs_pkg::CHK_DONE:
                    short_found_reg <= 1'b0;
                default:
                    chk_reg <= pfs_pkg::CHK_IDLE;
            endcase
        end
    end

    assign checking       = (chk_reg != pfs_pkg::CHK_DONE);
    assign CHECK_STEP_OUT = {chk_reg == pfs_pkg::CHK_SUPPLY, chk_reg == pfs_pkg::CHK_GROUND};

    // ------------------------------------------------------------------
    // Hold edges, thermal latch, overload guards
    // ------------------------------------------------------------------
    logic hold_ab_d_reg;
    logic hold_cd_d_reg;
    logic hold_rise;
    logic hold_any;
    logic therm_reg;

    // Hold inputs are ignored while the check runs.
    always_ff @(posedge MCLK_IN or negedge RESET_N_IN)
    begin
        if (!RESET_N_IN)
        begin
            hold_ab_d_reg <= 1'b1;
            hold_cd_d_reg <= 1'b1;
        end
        else
        begin
            hold_ab_d_reg <= hold_ab_n;
            hold_cd_d_reg <= hold_cd_n;
        end
    end

    assign hold_rise = !checking && ((hold_ab_n && !hold_ab_d_reg) || (hold_cd_n && !hold_cd_d_reg));
    assign hold_any  = !checking && (!hold_ab_n || !hold_cd_n);

    // Thermal latch; an over-temperature sample wins over the clear.
    always_ff @(posedge MCLK_IN or negedge RESET_N_IN)
    begin
        if (!RESET_N_IN)
            therm_reg <= 1'b0;
        else if (tshut)
            therm_reg <= 1'b1;
        else if (hold_any)
            therm_reg <= 1'b0;
    end

    logic [1:0] ol;
    logic [1:0] lim;

    // Separate guards for pair A/B and pair C/D; a hold rising edge on either pair releases both.
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_pair
            pfs_pair_guard u_guard (
                .clk_in       (MCLK_IN),
                .rst_n_in     (RESET_N_IN),
                .trip_in      (oc[2*gi] | oc[2*gi+1]),
                .release_in   (hold_rise),
                .limit_out    (lim[gi]),
                .overload_out (ol[gi])
            );
        end
    endgenerate

    assign CURRENT_LIMIT_OUT = {lim[1], lim[1], lim[0], lim[0]};

    // ------------------------------------------------------------------
    // High-impedance mapping
    // ------------------------------------------------------------------
    logic [3:0] hiz_next;
    logic [3:0] hiz_reg;
    logic       err_ab;
    logic       err_cd;

    assign err_ab = lerr[0] | lerr[1];
    assign err_cd = lerr[2] | lerr[3];

    // Combines all shutdown causes per half-bridge.
    always_comb
    begin
        hiz_next = 4'h0;
        if (mode == pfs_pkg::MODE_PARALLEL)
        begin
            if (err_ab || err_cd)
                hiz_next = 4'hF;
        end
        else
        begin
            if (err_ab)
                hiz_next[1:0] = 2'h3;
            if (err_cd)
                hiz_next[3:2] = 2'h3;
        end
        hiz_next = hiz_next | bst_uv;
        if (ol[0] || (!checking && !hold_ab_n))
            hiz_next[1:0] = 2'h3;
        if (ol[1] || (!checking && !hold_cd_n))
            hiz_next[3:2] = 2'h3;
        if (uv || tshut || therm_reg || checking)
            hiz_next = 4'hF;
    end

    always_ff @(posedge MCLK_IN or negedge RESET_N_IN)
    begin
        if (!RESET_N_IN)
            hiz_reg <= 4'hF;
        else
            hiz_reg <= hiz_next;
    end

    assign BRIDGE_HIZ_OUT = hiz_reg;

    // Recharge pulses while a bootstrap is low.
    logic [3:0] rchg_reg;
    always_ff @(posedge MCLK_IN or negedge RESET_N_IN)
    begin
        if (!RESET_N_IN)
            rchg_reg <= 4'h0;
        else
            rchg_reg <= bst_uv & ~rchg_reg;
    end

    assign RECHARGE_OUT = rchg_reg;

    // ------------------------------------------------------------------
    // Fault pins
    // ------------------------------------------------------------------
    logic sd_n_reg;
    logic warn_n_reg;
    logic fault_any;

    assign fault_any = uv || tshut || therm_reg || (|ol) || err_ab || err_cd || (|bst_uv);

    // Check holds shutdown low; otherwise hold low forces it high.
    always_ff @(posedge MCLK_IN or negedge RESET_N_IN)
    begin
        if (!RESET_N_IN)
        begin
            sd_n_reg   <= 1'b0;
            warn_n_reg <= 1'b1;
        end
        else
        begin
            if (checking)
                sd_n_reg <= 1'b0;
            else if (hold_any)
                sd_n_reg <= 1'b1;
            else
                sd_n_reg <= !fault_any;
            warn_n_reg <= !(twarn || tshut || therm_reg);
        end
    end

    // Open drain: drive only the low level.
    assign SHUTDOWN_FAULT_N_OUT    = 1'b0;
    assign SHUTDOWN_FAULT_N_OE_OUT = !sd_n_reg;
    assign THERMAL_WARN_N_OUT      = 1'b0;
    assign THERMAL_WARN_N_OE_OUT   = !warn_n_reg;

    // Status word for software.
    always_comb
    begin
        status = 32'h00000000;
        status[pfs_pkg::ST_SD_N]     = sd_n_reg;
        status[pfs_pkg::ST_WARN_N]   = warn_n_reg;
        status[pfs_pkg::ST_THERM]    = therm_reg;
        status[pfs_pkg::ST_OL_AB]    = ol[0];
        status[pfs_pkg::ST_OL_CD]    = ol[1];
        status[pfs_pkg::ST_UV]       = uv;
        status[pfs_pkg::ST_SHORTCHK] = checking;
        status[pfs_pkg::ST_SHORTFND] = short_found_reg;
    end

endmodule : pfs_supervisor

// ===== tb/pfs_supervisor_monitor.sv
`timescale 1ns/1ns
// -------------------------------------------------
// Port checker for the fault supervisor
// -------------------------------------------------
module pfs_supervisor_monitor (
    input wire logic        MCLK_IN,
    input wire logic        RESET_N_IN,
    input wire logic        WB_CYC_IN,
    input wire logic        WB_STB_IN,
    input wire logic        WB_WE_IN,
    input wire logic [7:0]  WB_ADR_IN,
    input wire logic [31:0] WB_DAT_OUT,
    input wire logic        WB_ACK_OUT,
    input wire logic        PAIR_AB_HOLD_N_IN,
    input wire logic        PAIR_CD_HOLD_N_IN,
    input wire logic        SUPPLY_UNDERVOLT_FAULT_IN,
    input wire logic        TEMP_WARN_IN,
    input wire logic        TEMP_SHUTDOWN_IN,
    input wire logic [3:0]  OVERCURRENT_TRIP_IN,
    input wire logic [3:0]  BRIDGE_HIZ_OUT,
    input wire logic [3:0]  CURRENT_LIMIT_OUT,
    input wire logic [1:0]  CHECK_STEP_OUT,
    input wire logic        SHUTDOWN_FAULT_N_OE_OUT,
    input wire logic        THERMAL_WARN_N_OE_OUT
);
    logic hold_any;

    // Either pair is held by the controller.
    assign hold_any = !PAIR_AB_HOLD_N_IN || !PAIR_CD_HOLD_N_IN;

    // All checks use the core clock and sleep through reset.
    default clocking mon_cb @(posedge MCLK_IN);
    endclocking
    default disable iff (!RESET_N_IN);

    AST_ACK_ANSWER: assert property (WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT |=> WB_ACK_OUT)
        else $error("bus request not answered");
    AST_ACK_ONE: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
        else $error("ack longer than one cycle");
    AST_UNMAPPED_ZERO: assert property (WB_CYC_IN && WB_STB_IN && !WB_WE_IN && !WB_ACK_OUT
        && WB_ADR_IN > 8'h08 |=> WB_DAT_OUT == 32'h0) else $error("unmapped read not zero");
    AST_CHECK_SD_LOW: assert property (CHECK_STEP_OUT != 2'h0 |-> SHUTDOWN_FAULT_N_OE_OUT)
        else $error("shutdown released during check");
    AST_STEP_ORDER: assert property ($rose(CHECK_STEP_OUT[1]) |-> $past(CHECK_STEP_OUT[0]))
        else $error("supply step not after ground step");
    AST_STEP_SINGLE: assert property (CHECK_STEP_OUT != 2'h3)
        else $error("both check steps at once");
    AST_HOLD_SD_HIGH: assert property ((hold_any && CHECK_STEP_OUT == 2'h0)[*4] |-> !SHUTDOWN_FAULT_N_OE_OUT)
        else $error("shutdown low while held");
    AST_THERM_ALL_HIZ: assert property (TEMP_SHUTDOWN_IN[*4] |-> BRIDGE_HIZ_OUT == 4'hF && THERMAL_WARN_N_OE_OUT)
        else $error("thermal shutdown not applied");
    AST_WARN_LOW: assert property (TEMP_WARN_IN[*4] |-> THERMAL_WARN_N_OE_OUT)
        else $error("warning not signalled");
    AST_UV_ALL_HIZ: assert property ((SUPPLY_UNDERVOLT_FAULT_IN && !hold_any)[*4]
        |-> BRIDGE_HIZ_OUT == 4'hF && SHUTDOWN_FAULT_N_OE_OUT)
        else $error("undervoltage not applied");
    AST_LIMIT_AB: assert property ((OVERCURRENT_TRIP_IN[0])[*3] ##0 !BRIDGE_HIZ_OUT[0]
        |-> (CURRENT_LIMIT_OUT[1:0] == 2'h3) or (CURRENT_LIMIT_OUT[1:0] == 2'h0 ##1 BRIDGE_HIZ_OUT[1:0] == 2'h3))
        else $error("pair AB not limiting");

    // Main scenarios reached.
    COV_SUPPLY_STEP: cover property ($rose(CHECK_STEP_OUT[1]));
    COV_THERMAL: cover property (TEMP_SHUTDOWN_IN ##4 BRIDGE_HIZ_OUT == 4'hF);
    COV_LIMIT: cover property ($rose(CURRENT_LIMIT_OUT[0]));
endmodule : pfs_supervisor_monitor

bind pfs_supervisor pfs_supervisor_monitor i_mon (
    .MCLK_IN(MCLK_IN), .RESET_N_IN(RESET_N_IN), .WB_CYC_IN(WB_CYC_IN), .WB_STB_IN(WB_STB_IN),
    .WB_WE_IN(WB_WE_IN), .WB_ADR_IN(WB_ADR_IN), .WB_DAT_OUT(WB_DAT_OUT), .WB_ACK_OUT(WB_ACK_OUT),
    .PAIR_AB_HOLD_N_IN(PAIR_AB_HOLD_N_IN), .PAIR_CD_HOLD_N_IN(PAIR_CD_HOLD_N_IN),
    .SUPPLY_UNDERVOLT_FAULT_IN(SUPPLY_UNDERVOLT_FAULT_IN), .TEMP_WARN_IN(TEMP_WARN_IN),
    .TEMP_SHUTDOWN_IN(TEMP_SHUTDOWN_IN), .OVERCURRENT_TRIP_IN(OVERCURRENT_TRIP_IN),
    .BRIDGE_HIZ_OUT(BRIDGE_HIZ_OUT), .CURRENT_LIMIT_OUT(CURRENT_LIMIT_OUT), .CHECK_STEP_OUT(CHECK_STEP_OUT),
    .SHUTDOWN_FAULT_N_OE_OUT(SHUTDOWN_FAULT_N_OE_OUT), .THERMAL_WARN_N_OE_OUT(THERMAL_WARN_N_OE_OUT)
);

// ===== tb/pfs_ctrl_model.sv
`timescale 1ns/1ns
// -------------------------------------------------
// System controller on the fault pins
// -------------------------------------------------
module pfs_ctrl_model #(
    parameter int WAIT_CYC = pfs_pkg::RELEASE_CYC
) (
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    input  wire logic ab_req_n_in,
    input  wire logic cd_req_n_in,
    input  wire logic sd_oe_in,
    input  wire logic warn_oe_in,
    output logic      ab_hold_n_out,
    output logic      cd_hold_n_out,
    output logic      sd_pin_out,
    output logic      warn_pin_out
);
    logic [pfs_pkg::CNT_W-1:0] since_fall_reg;
    logic                      sd_last_reg;

    // Pull-ups keep each pin high unless the device sinks it.
    assign sd_pin_out   = !sd_oe_in;
    assign warn_pin_out = !warn_oe_in;

    // Counts cycles since the shutdown pin last fell.
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            since_fall_reg <= '0;
            sd_last_reg    <= 1'b0;
        end
        else
        begin
            sd_last_reg <= sd_pin_out;
            if (sd_last_reg && !sd_pin_out)
                since_fall_reg <= '0;
            else if (since_fall_reg < pfs_pkg::CNT_W'(WAIT_CYC))
                since_fall_reg <= since_fall_reg + 1'b1;
        end
    end

    // Holds go low at once; a rising edge waits out the release delay.
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            ab_hold_n_out <= 1'b1;
            cd_hold_n_out <= 1'b1;
        end
        else
        begin
            if (!ab_req_n_in)
                ab_hold_n_out <= 1'b0;
            else if (since_fall_reg >= pfs_pkg::CNT_W'(WAIT_CYC))
                ab_hold_n_out <= 1'b1;
            if (!cd_req_n_in)
                cd_hold_n_out <= 1'b0;
            else if (since_fall_reg >= pfs_pkg::CNT_W'(WAIT_CYC))
                cd_hold_n_out <= 1'b1;
        end
    end
endmodule : pfs_ctrl_model

// ===== tb/pfs_supervisor_tb.sv
`timescale 1ns/1ns
// -------------------------------------------------
// Testbench for the fault supervisor
// -------------------------------------------------
module pfs_supervisor_tb;
    logic        mclk, rst_n, cyc, stb, we, ack, ab_req_n, cd_req_n, ab_n, cd_n;
    logic        uv, twarn, tsd, sd_oe, wn_oe, sd_pin, wn_pin;
    logic [7:0]  adr;
    logic [31:0] wdat, rdat, r1;
    logic [3:0]  trip, boot, loc, sgnd, ssup, hiz, lim, rech;
    logic [1:0]  step;
    int          errors = 0;
    int          checked = 0;

    pfs_supervisor i_dut (.MCLK_IN(mclk), .RESET_N_IN(rst_n), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
        .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(4'hF), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat),
        .WB_ACK_OUT(ack), .PAIR_AB_HOLD_N_IN(ab_n), .PAIR_CD_HOLD_N_IN(cd_n),
        .SUPPLY_UNDERVOLT_FAULT_IN(uv), .TEMP_WARN_IN(twarn), .TEMP_SHUTDOWN_IN(tsd),
        .OVERCURRENT_TRIP_IN(trip), .BOOTSTRAP_UNDERVOLT_IN(boot), .LOCAL_ERROR_IN(loc),
        .PIN_SHORT_GND_IN(sgnd), .PIN_SHORT_SUPPLY_IN(ssup), .BRIDGE_HIZ_OUT(hiz),
        .CURRENT_LIMIT_OUT(lim), .RECHARGE_OUT(rech), .CHECK_STEP_OUT(step),
        .SHUTDOWN_FAULT_N_OUT(), .SHUTDOWN_FAULT_N_OE_OUT(sd_oe),
        .THERMAL_WARN_N_OUT(), .THERMAL_WARN_N_OE_OUT(wn_oe));

    pfs_ctrl_model #(.WAIT_CYC(300)) i_ctrl (.clk_in(mclk), .rst_n_in(rst_n), .ab_req_n_in(ab_req_n),
        .cd_req_n_in(cd_req_n), .sd_oe_in(sd_oe), .warn_oe_in(wn_oe), .ab_hold_n_out(ab_n),
        .cd_hold_n_out(cd_n), .sd_pin_out(sd_pin), .warn_pin_out(wn_pin));

    // Free-running core clock.
    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
    endtask : idle

    task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do
        begin
            @(posedge mclk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        r1 = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        chk(32'(ack), 32'h1);
    endtask : wb_xfer

    task automatic wb_rd(input logic [7:0] a, input logic [31:0] exp);
        wb_xfer(1'b0, a, 32'h0);
        chk(r1, exp);
    endtask : wb_rd

    task automatic wait_step(input logic [1:0] v);
        int n;
        n = 0;
        while (step !== v && n < 6000)
        begin
            @(posedge mclk);
            n++;
        end
        chk(32'(step), 32'(v));
    endtask : wait_step

    task automatic print_verdict();
        $display("checks %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : print_verdict

    // Cuts a hang short well past the expected run length.
    initial
    begin
        #(40 * 40000);
        errors++;
        print_verdict();
    end

    // Test sequence.
    initial
    begin
        {rst_n, cyc, stb, we, uv, twarn, tsd} = 7'h0;
        {ab_req_n, cd_req_n} = 2'h3;
        {trip, boot, loc, ssup} = 16'h0;
        adr = 8'h0;
        wdat = 32'h0;
        sgnd = 4'h4;
        idle(6);
        rst_n <= 1'b1;
        idle(3);
        chk(32'(step), 32'h1);
        ab_req_n <= 1'b0;
        idle(5);
        chk(32'(sd_pin), 32'h0);
        ab_req_n <= 1'b1;
        idle(3000);
        chk(32'(step), 32'h1);
        chk(32'(hiz), 32'hF);
        wb_rd(pfs_pkg::ADDR_STATUS, 32'hC2);
        sgnd <= 4'h0;
        wait_step(2'h2);
        ssup <= 4'h8;
        idle(2600);
        chk(32'(step), 32'h2);
        ssup <= 4'h0;
        wait_step(2'h0);
        idle(5);
        chk({30'h0, sd_pin, wn_pin}, 32'h3);
        chk(32'(hiz), 32'h0);
        $display("test startup check done");
        wb_rd(pfs_pkg::ADDR_STATUS, 32'h3);
        wb_xfer(1'b1, pfs_pkg::ADDR_HIZ, 32'hF);
        wb_rd(pfs_pkg::ADDR_HIZ, 32'h0);
        wb_rd(8'h20, 32'h0);
        twarn <= 1'b1;
        idle(5);
        chk({30'h0, sd_pin, wn_pin}, 32'h2);
        twarn <= 1'b0;
        uv <= 1'b1;
        idle(5);
        chk({26'h0, hiz, sd_pin, wn_pin}, 32'h3D);
        uv <= 1'b0;
        idle(5);
        chk({26'h0, hiz, sd_pin, wn_pin}, 32'h3);
        $display("test warning and supply done");
        for (int m = 0; m < 3; m++)
        begin
            wb_xfer(1'b1, pfs_pkg::ADDR_CTRL, 32'hC | 32'(m));
            wb_rd(pfs_pkg::ADDR_CTRL, 32'hC | 32'(m));
            for (int b = 0; b < 4; b++)
            begin
                loc <= 4'h1 << b;
                idle(5);
                chk(32'(hiz), (m == 1) ? 32'hF : ((b < 2) ? 32'h3 : 32'hC));
                chk(32'(sd_pin), 32'h0);
                loc <= 4'h0;
                idle(5);
                chk(32'(hiz), 32'h0);
            end
        end
        wb_xfer(1'b1, pfs_pkg::ADDR_CTRL, 32'hC);
        boot <= 4'h2;
        idle(5);
        chk(32'(hiz), 32'h2);
        r1 = 32'(rech);
        idle(1);
        chk(r1 ^ 32'(rech), 32'h2);
        boot <= 4'h0;
        $display("test error mapping done");
        trip <= 4'h1;
        idle(5);
        chk({24'h0, lim, hiz}, 32'h30);
        idle(260);
        chk({27'h0, hiz, sd_pin}, 32'h6);
        trip <= 4'h0;
        idle(5);
        chk(32'(hiz), 32'h3);
        ab_req_n <= 1'b0;
        idle(5);
        chk({27'h0, hiz, sd_pin}, 32'h7);
        ab_req_n <= 1'b1;
        idle(350);
        chk({27'h0, hiz, sd_pin}, 32'h1);
        $display("test overload done");
        tsd <= 1'b1;
        idle(5);
        chk({26'h0, hiz, sd_pin, wn_pin}, 32'h3C);
        tsd <= 1'b0;
        idle(5);
        chk(32'(hiz), 32'hF);
        cd_req_n <= 1'b0;
        idle(5);
        cd_req_n <= 1'b1;
        idle(350);
        chk({26'h0, hiz, sd_pin, wn_pin}, 32'h3);
        $display("test thermal done");
        print_verdict();
    end
endmodule : pfs_supervisor_tb
